// ===== cbbr_regs.vh
// Register offsets, field positions and reset values of the bridge register bank
`ifndef CBBR_REGS_VH
`define CBBR_REGS_VH

`define CBBR_OFF_SEC_STATUS 8'h16
`define CBBR_OFF_PRI_BUS 8'h18
`define CBBR_OFF_SEC_BUS 8'h19
`define CBBR_OFF_SUB_BUS 8'h1a

`define CBBR_BIT_PARITY 15
`define CBBR_BIT_SERR 14
`define CBBR_BIT_MABORT 13
`define CBBR_BIT_TABORT_RX 12
`define CBBR_BIT_TABORT_SIG 11
`define CBBR_BIT_DPAR 8

`define CBBR_DEVSEL_CODE 2'h1
`define CBBR_BUS_RESET 8'h00
`define CBBR_STATUS_RESET 16'h0200

`define CBBR_CFG_IGNORE 2'h0
`define CBBR_CFG_TYPE0 2'h1
`define CBBR_CFG_TYPE1 2'h2

`endif

// ===== cbbr_bus_regs.v
// Three eight-bit bus number registers
`timescale 1ns/10ps
`default_nettype none
`include "cbbr_regs.vh"

module cbbr_bus_regs (
    input wire mclk,
    input wire rst_n,
    input wire wr_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] pri_reg,
    output reg [7:0] sec_reg,
    output reg [7:0] sub_reg
);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pri_reg <= `CBBR_BUS_RESET; // [R12]
            sec_reg <= `CBBR_BUS_RESET; // [R13]
            sub_reg <= `CBBR_BUS_RESET; // [R14]
        end else if (wr_en) begin
            case (addr)
                `CBBR_OFF_PRI_BUS: pri_reg <= wdata; // [R12]
                `CBBR_OFF_SEC_BUS: sec_reg <= wdata; // [R13]
                `CBBR_OFF_SUB_BUS: sub_reg <= wdata; // [R14]
                default: ;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== cbbr_cfg_route.v
// Configuration cycle forwarding decision from the bus numbers
`timescale 1ns/10ps
`default_nettype none
`include "cbbr_regs.vh"

module cbbr_cfg_route (
    input wire [7:0] sec_bus,
    input wire [7:0] sub_bus,
    input wire [7:0] target_bus,
    output reg [1:0] route
);

    always @* begin
        if (target_bus == sec_bus) begin
            route = `CBBR_CFG_TYPE0; // [R17]
        end else if (target_bus > sec_bus && target_bus <= sub_bus) begin
            route = `CBBR_CFG_TYPE1; // [R17]
        end else begin
            route = `CBBR_CFG_IGNORE;
        end
    end

endmodule
`default_nettype wire

// ===== cbbr_bank.v
// Secondary status register and bus number registers of the card bridge
// What this block does
// [R01] Bit 15 latches a parity error seen on the card side, address or data phase.
// [R02] Bit 14 latches a system error reported by a card.
// [R03] The bridge never drives the card system error signal.
// [R04] Bit 13 latches a master abort on a cycle the bridge started.
// [R05] Bit 12 latches a target abort received on a cycle the bridge started.
// [R06] Bit 11 latches a target abort the bridge signaled as target.
// [R07] Bits 10 to 9 read constant 01b, medium select timing.
// [R08] Bit 8 latches only on a parity error report while mastering with parity response on.
// [R09] Bits 7 and 6 read zero.
// [R10] Bit 5 reads zero since the card clock is at most 33 MHz.
// [R11] Bits 4 to 0 read zero.
// [R12] Primary bus number at 18h, read/write, resets to 00h.
// [R13] Card bus number at 19h, read/write, resets to 00h.
// [R14] Subordinate bus number at 1Ah, read/write, resets to 00h.
// [R15] The card and subordinate bus numbers decide configuration forwarding; the primary bus number takes no part.
// [R16] Writing one clears a status flag, writing zero leaves it.
// [R17] Equal to card bus gives type 0, within range gives type 1, else ignored.
`timescale 1ns/10ps
`default_nettype none
`include "cbbr_regs.vh"

module cbbr_bank (
    // Clock and reset
    input wire MCLK,
    input wire RST_N,
    // Register access, byte addressed
    input wire CFG_WR,
    input wire CFG_RD,
    input wire [7:0] CFG_ADDR,
    input wire [15:0] CFG_WDATA,
    input wire [1:0] CFG_BE,
    output reg [15:0] CFG_RDATA,
    // Card side events, one-cycle pulses
    input wire CB_PARITY_ERR,
    input wire CB_SERR_SEEN,
    input wire CB_MABORT,
    input wire CB_TABORT_RX,
    input wire CB_TABORT_SIG,
    input wire CB_PERR_SEEN,
    input wire CB_MASTERING,
    input wire PARITY_RESP_EN,
    // Card system error pin, never driven
    output reg CSERR_OUT,
    output reg CSERR_OE,
    // Configuration forwarding request
    input wire CFG_REQ,
    input wire CFG_TYPE1,
    input wire [7:0] CFG_BUS,
    output reg CFG_FWD_VALID,
    output reg [1:0] CFG_FWD_ROUTE
);

    reg [4:0] flag_reg;
    reg [4:0] flag_next;
    reg dpar_reg;
    reg dpar_next;
    wire [7:0] pri_bus;
    wire [7:0] sec_bus;
    wire [7:0] sub_bus;
    wire [1:0] route;
    wire [15:0] status_word;
    wire [4:0] set_vec;
    wire [4:0] clr_vec;
    wire clr_dpar;
    wire hi_wr;

    // Only the high lane holds clearable flags; low lane writes fall away
    assign hi_wr = CFG_WR && CFG_BE[1] && CFG_ADDR == `CBBR_OFF_SEC_STATUS;

    assign set_vec = {CB_PARITY_ERR, CB_SERR_SEEN, CB_MABORT, CB_TABORT_RX,
        CB_TABORT_SIG}; // [R01] [R02] [R04] [R05] [R06]
    assign clr_vec = hi_wr ? CFG_WDATA[15:11] : 5'h00; // [R16]
    assign clr_dpar = hi_wr && CFG_WDATA[`CBBR_BIT_DPAR]; // [R16]

    // Bus numbers written one byte per access on the low lane
    cbbr_bus_regs u_bus (
        .mclk(MCLK),
        .rst_n(RST_N),
        .wr_en(CFG_WR && CFG_BE[0]),
        .addr(CFG_ADDR),
        .wdata(CFG_WDATA[7:0]),
        .pri_reg(pri_bus),
        .sec_reg(sec_bus),
        .sub_reg(sub_bus)
    );

    cbbr_cfg_route u_route (
        .sec_bus(sec_bus),
        .sub_bus(sub_bus),
        .target_bus(CFG_BUS),
        .route(route)
    );

    // Set wins over a clear in the same cycle
    always @* begin
        flag_next = (flag_reg & ~clr_vec) | set_vec; // [R16]
        dpar_next = dpar_reg & ~clr_dpar;
        if (CB_PERR_SEEN && CB_MASTERING && PARITY_RESP_EN) begin
            dpar_next = 1'b1; // [R08]
        end
    end

    assign status_word = {flag_reg, `CBBR_DEVSEL_CODE, dpar_reg, // [R07]
        3'h0, 5'h00}; // [R09] [R10] [R11]

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_reg <= 5'h00;
            dpar_reg <= 1'b0;
            CFG_RDATA <= 16'h0000;
            CSERR_OUT <= 1'b0;
            CSERR_OE <= 1'b0;
            CFG_FWD_VALID <= 1'b0;
            CFG_FWD_ROUTE <= `CBBR_CFG_IGNORE;
        end else begin
            flag_reg <= flag_next;
            dpar_reg <= dpar_next;
            CSERR_OUT <= 1'b0; // [R03]
            CSERR_OE <= 1'b0; // [R03]
            if (CFG_RD) begin
                case (CFG_ADDR)
                    `CBBR_OFF_SEC_STATUS: CFG_RDATA <= status_word;
                    `CBBR_OFF_PRI_BUS: CFG_RDATA <= {8'h00, pri_bus}; // [R12]
                    `CBBR_OFF_SEC_BUS: CFG_RDATA <= {8'h00, sec_bus}; // [R13]
                    `CBBR_OFF_SUB_BUS: CFG_RDATA <= {8'h00, sub_bus}; // [R14]
                    default: CFG_RDATA <= 16'h0000;
                endcase
            end
            // Type 0 requests target this bridge itself, not forwarded
            CFG_FWD_VALID <= CFG_REQ;
            if (CFG_REQ) begin
                CFG_FWD_ROUTE <= CFG_TYPE1 ? route : `CBBR_CFG_IGNORE; // [R15] [R17]
            end
        end
    end

endmodule
`default_nettype wire

// ===== cbbr_bank_monitor.sv
// Checker of the bridge register bank ports
`timescale 1ns/10ps
`default_nettype none
module cbbr_bank_monitor (
    // Clock and reset
    input wire MCLK, RST_N,
    // Watched ports
    input wire CFG_RD, CB_MABORT, CSERR_OUT, CSERR_OE, CFG_REQ, CFG_FWD_VALID,
    input wire [7:0] CFG_ADDR,
    input wire [15:0] CFG_RDATA
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence rs; CFG_RD && CFG_ADDR == 8'h16; endsequence
    a_cserr_oe_low: assert property (!CSERR_OE) else $error("pin enabled");
    a_cserr_out_low: assert property (!CSERR_OUT) else $error("pin driven");
    a_fwd_pulse: assert property (CFG_REQ |=> CFG_FWD_VALID) else $error("no valid");
    a_fwd_cause: assert property (CFG_FWD_VALID |-> $past(CFG_REQ)) else $error("stray");
    a_devsel_code: assert property (rs |=> CFG_RDATA[10:9] == 2'h1) else $error("code");
    a_caps_zero: assert property (rs |=> CFG_RDATA[7:5] == 3'h0) else $error("caps");
    a_rsvd_zero: assert property (rs |=> CFG_RDATA[4:0] == 5'h00) else $error("rsvd");
    a_mabort_flag: assert property (CB_MABORT ##1 rs |=> CFG_RDATA[13]) else $error("abort");
    cover property (CB_MABORT ##1 rs);
    cover property (CFG_FWD_VALID);
    cover property (rs);
endmodule
bind cbbr_bank cbbr_bank_monitor mon (.*);
`default_nettype wire

// ===== cbbr_card_model.sv
// Card side model raising one-cycle event pulses
`timescale 1ns/10ps
`default_nettype none
module cbbr_card_model (
    // Clock, request and pulses
    input wire mclk,
    input wire [4:0] fire,
    output logic [4:0] ev
);
    // One cycle late, as a card reports after its own phase
    always @(posedge mclk) ev <= fire;
endmodule
`default_nettype wire

// ===== cbbr_bank_tb.sv
// Bench of the bridge register bank
`timescale 1ns/10ps
`default_nettype none
module cbbr_bank_tb;
    logic MCLK = 0, RST_N = 0, CFG_WR = 0, CFG_RD = 0, CFG_REQ = 0, CFG_TYPE1 = 0, CFG_FWD_VALID;
    logic CB_PERR_SEEN = 0, CB_MASTERING = 0, PARITY_RESP_EN = 0, CSERR_OUT, CSERR_OE;
    logic [15:0] CFG_WDATA = 0, CFG_RDATA;
    logic [7:0] CFG_ADDR = 0, CFG_BUS = 0, s;
    logic [4:0] fire = 0;
    logic [1:0] CFG_BE = 3, CFG_FWD_ROUTE;
    wire CB_PARITY_ERR, CB_SERR_SEEN, CB_MABORT, CB_TABORT_RX, CB_TABORT_SIG;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #20 MCLK = ~MCLK;
    cbbr_card_model card (.mclk(MCLK), .fire(fire), .ev({CB_PARITY_ERR,
        CB_SERR_SEEN, CB_MABORT, CB_TABORT_RX, CB_TABORT_SIG}));
    cbbr_bank dut (.*);
    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, g);
        num_checks++;
        n_mismatch += 32'(g !== e);
        if (g !== e) $display("unexpected %s: expected %h, seen %h", n, e, g);
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge MCLK) {CFG_WR, CFG_RD, CFG_ADDR, CFG_WDATA} <= {w, !w, a, d};
        @(posedge MCLK) {CFG_WR, CFG_RD} <= 2'h0;
        #1 if (!w) chk("read data", d, CFG_RDATA);
    endtask
    function logic [1:0] route(logic ty, logic [7:0] b);
        return !ty ? 2'h0 : b == s + 8'h01 ? 2'h1 : b == s + 8'h02 ? 2'h2 : 2'h0;
    endfunction
    task fwd(input logic ty, input logic [7:0] b);
        @(posedge MCLK) {CFG_REQ, CFG_TYPE1, CFG_BUS} <= {1'h1, ty, b};
        @(posedge MCLK) CFG_REQ <= 0;
        #1 chk("route", {1'h1, route(ty, b)}, {CFG_FWD_VALID, CFG_FWD_ROUTE});
    endtask
    always @(posedge MCLK) if (++cyc == 900) begin
        n_mismatch++;
        end_of_test();
    end
    initial begin
        s = 8'($urandom(2) % 251);
        repeat (3) @(posedge MCLK);
        RST_N <= 1;
        #1 chk("pin drive", 16'h0000, {14'h0000, CSERR_OE, CSERR_OUT});
        acc(0, 8'h16, 16'h0200);
        acc(0, 8'h1a, 0);
        for (int i = 0; i < 6; i++) acc(i < 3, 8'h18 + 8'(i % 3), s + 8'(i % 3));
        for (int i = 0; i < 5; i++) begin
            @(posedge MCLK) fire <= 5'h01 << i;
            @(posedge MCLK) fire <= 0;
            acc(0, 8'h16, 16'h0200 | 16'h0800 << i);
            acc(1, 8'h16, 16'h0800 << i);
        end
        for (int j = 0; j < 8; j++) begin
            @(posedge MCLK) {CB_PERR_SEEN, CB_MASTERING, PARITY_RESP_EN} <= 3'(j);
            @(posedge MCLK) {CB_PERR_SEEN, CB_MASTERING, PARITY_RESP_EN} <= 0;
            acc(0, 8'h16, j == 7 ? 16'h0300 : 16'h0200);
            acc(1, 8'h16, 16'h0100);
        end
        @(posedge MCLK) fire <= 5'h04;
        @(posedge MCLK) {fire, CFG_BE} <= {5'h00, 2'h1};
        acc(1, 8'h16, 16'hffff);
        CFG_BE <= 2'h3;
        acc(0, 8'h16, 16'h2200);
        acc(1, 8'h16, 16'h2000);
        acc(0, 8'h16, 16'h0200);
        for (int b = 0; b < 5; b++) fwd(b < 4, s + 8'(b));
        end_of_test();
    end
endmodule
`default_nettype wire
